// ---- rtl/frc_arm.sv ----
/*
 Two-write protection unlock: a target value is taken only when written right after
 the opposite value. Assumes same-clock write strobes.
*/
`timescale 1ns/100ps
`include "frc_defs.svh"
module frc_arm (
   input  wire logic sys_clk,   // Clock
   input  wire logic resetn,    // Sync reset
   input  wire logic wr,        // Write to the bit's register
   input  wire logic wdata,     // Value written
   input  wire logic other_wr,  // Any other register write
   input  wire logic target,    // Value that needs arming
   output logic      allow      // Target write is allowed now
);
   logic       armed;           // Opposite value just written
   logic [3:0] age;             // Cycles since arming
   // Any other write breaks the pair; the window stops runaway arming
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         armed <= 1'b0;
         age   <= 4'h0;
      end else if (wr) begin
         armed <= (wdata != target);
         age   <= 4'h0;
      end else if (other_wr || age == `FRC_ARM_WINDOW) begin
         armed <= 1'b0;
      end else if (armed) begin
         age <= age + 4'h1;
      end
   end
   assign allow = armed;
endmodule : frc_arm

// ---- rtl/frc_ctrl.sv ----
/*
 Device end: the three flash control registers reached over AHB-Lite, block
 protection, busy/error flags, stop, suspend and progress flags.
 Assumes the sequencer end on the link and a single 100 MHz clock.
*/
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "frc_defs.svh"
// How it works
// R1 - ready low while programming, erasing or suspended
// R2 - commands accepted only with rewrite enabled
// R3 - lock release gates blocks 0 to 3
// R4 - block 0 needs release and lock0 clear
// R5 - block 1 needs release and lock1 clear
// R6 - stop blocks accesses, resets flash control
// R7 - software stops flash if ready never returns
// R8 - read-only program and erase error flags
// R9 - mode select one means CPU-held mode
// R10 - suspend works only with suspend enable
// R11 - erase suspend request gated, cleared resumes
// R12 - program suspend request gated, cleared resumes
// R13 - erase in progress through suspend
// R14 - program in progress through suspend
// R15 - read permitted only when idle or suspended
// R16 - software limits low-power read usage
// R17 - protected bits need zero then one
// R18 - clear status clears both error flags
// R19 - stop acts only with rewrite enabled
// R20 - rewrite disable clears lock release
// R21 - rewrite disable clears mode select
// R22 - lock bits writable in rewrite mode, guarded
// R23 - clear status is byte 50h
module frc_ctrl
   import frc_pkg::*;
(
   input  wire logic   sys_clk,     // 100 MHz clock
   input  wire logic   resetn,      // Sync reset, active low
   input  wire logic   hsel,        // AHB-Lite select
   input  wire logic [31:0] haddr,  // Address
   input  wire logic [1:0]  htrans, // Transfer type
   input  wire logic        hwrite, // Write
   input  wire logic [2:0]  hsize,  // Size
   input  wire logic [31:0] hwdata, // Write data
   input  wire logic        hready, // Bus ready in
   output logic [31:0]      hrdata, // Read data
   output logic             hreadyout, // Slave ready
   output logic             hresp,  // Always OKAY
   input  wire logic        irq_pending, // Enabled interrupt request
   output logic             flash_access_block, // Flash accesses blocked
   frc_link_if.ctrl         link    // Sequencer side
);
   import frc_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // Bus slave
   logic       wr_pend;           // Data phase of a write
   logic [3:0] wr_addr;           // Latched address
   logic       rw_en, lock_rel, stop, perr, eerr;   // Status/control bits
   logic       sel, lock0, lock1;                   // Mode bits
   logic       sus_en, esus, psus, lpr;             // Suspend bits
   logic       eprog, pprog;                        // Progress flags
   wire        take    = hsel && hready && htrans[1];
   wire [7:0]  wd      = hwdata[7:0];
   wire        wr_stat = wr_pend && wr_addr == `FRC_ADDR_STATUS;
   wire        wr_mode = wr_pend && wr_addr == `FRC_ADDR_MODE;
   wire        wr_sus  = wr_pend && wr_addr == `FRC_ADDR_SUSPEND;
   wire        wr_cmd  = wr_pend && wr_addr == `FRC_ADDR_COMMAND;
   wire        ready   = !(link.seq_busy || eprog || pprog);                       // R1
   wire        rdok    = !link.seq_busy || link.suspended;                         // R15
   wire [7:0]  r_stat  = {eerr, perr, 2'b00, stop, lock_rel, rw_en, ready};         // R8
   wire [7:0]  r_mode  = {1'b0, lock1, lock0, 3'b000, sel, 1'b0};
   wire [7:0]  r_sus   = {lpr, rdok, 1'b0, pprog, eprog, psus, esus, sus_en};
   wire [7:0]  r_sel   = (haddr[3:0] == `FRC_ADDR_STATUS)  ? r_stat :
                         (haddr[3:0] == `FRC_ADDR_MODE)    ? r_mode :
                         (haddr[3:0] == `FRC_ADDR_SUSPEND) ? r_sus  : 8'h00;
   // Protection unlocks, one small module per guarded bit
   wire        any_wr = wr_pend;
   logic       ok_rw, ok_rel, ok_sel, ok_l0, ok_l1, ok_sus;
   frc_arm u_rw  (.sys_clk(sys_clk), .resetn(resetn), .wr(wr_stat), .wdata(wd[`FRC_B_RW_EN]),
                  .other_wr(any_wr && !wr_stat), .target(1'b1), .allow(ok_rw));      // R17
   frc_arm u_rel (.sys_clk(sys_clk), .resetn(resetn), .wr(wr_stat), .wdata(wd[`FRC_B_LOCK_REL]),
                  .other_wr(any_wr && !wr_stat), .target(1'b1), .allow(ok_rel));     // R17
   frc_arm u_sel (.sys_clk(sys_clk), .resetn(resetn), .wr(wr_mode), .wdata(wd[`FRC_B_SEL]),
                  .other_wr(any_wr && !wr_mode), .target(1'b1), .allow(ok_sel));     // R17
   frc_arm u_l0  (.sys_clk(sys_clk), .resetn(resetn), .wr(wr_mode), .wdata(wd[`FRC_B_LOCK0]),
                  .other_wr(any_wr && !wr_mode), .target(1'b0), .allow(ok_l0));      // R22
   frc_arm u_l1  (.sys_clk(sys_clk), .resetn(resetn), .wr(wr_mode), .wdata(wd[`FRC_B_LOCK1]),
                  .other_wr(any_wr && !wr_mode), .target(1'b0), .allow(ok_l1));      // R22
   frc_arm u_sus (.sys_clk(sys_clk), .resetn(resetn), .wr(wr_sus), .wdata(wd[`FRC_B_SUS_EN]),
                  .other_wr(any_wr && !wr_sus), .target(1'b1), .allow(ok_sus));      // R17
   // Bus: zero wait states, always OKAY; read data registered in the address phase
   // Ready and response are flops too, so every top output leaves a register
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 4'h0;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend   <= take && hwrite;
         wr_addr   <= haddr[3:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (take && !hwrite)
            hrdata <= {24'h0, r_sel};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Status/control and mode registers
   wire next_rw = wd[`FRC_B_RW_EN] ? (rw_en || ok_rw) : 1'b0;                        // R17
   wire rw_drop = wr_stat && !next_rw;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rw_en    <= 1'b0;
         lock_rel <= 1'b0;
         stop     <= 1'b0;
      end else if (wr_stat) begin
         rw_en    <= next_rw;
         lock_rel <= next_rw && wd[`FRC_B_LOCK_REL] && (lock_rel || ok_rel);          // R20
         stop     <= wd[`FRC_B_STOP];                                                 // R19
      end
   end
   // Mode select and locks; rewrite disable forces select back
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sel   <= 1'b0;
         lock0 <= 1'b1;
         lock1 <= 1'b1;
      end else if (rw_drop || !rw_en) begin
         sel <= 1'b0;                                                                 // R21
      end else if (wr_mode) begin
         sel   <= wd[`FRC_B_SEL] && (sel || ok_sel);                                  // R9
         // A 1 sets at once; a 0 clears only when armed, else the lock holds
         lock0 <= wd[`FRC_B_LOCK0] || (lock0 && !ok_l0);                              // R22
         lock1 <= wd[`FRC_B_LOCK1] || (lock1 && !ok_l1);                              // R22
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Commands, errors, progress
   // Block of the command now in its data phase; the link copy lags a cycle
   wire [1:0] cmd_blk = hwdata[9:8];
   wire blk_ok = lock_rel && (cmd_blk[1] ||
                 (cmd_blk == 2'h0 ? !lock0 : !lock1));                                // R3 R4 R5
   wire is_clr = wr_cmd && wd == `FRC_CMD_CLEAR;                                      // R23
   wire is_pe  = wr_cmd && (wd == `FRC_CMD_PROGRAM || wd == `FRC_CMD_ERASE);
   wire stopped = stop && rw_en;                                                      // R19
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         link.cmd_valid <= 1'b0;
         link.cmd_byte  <= 8'h0;
         link.cmd_block <= 2'h0;
      end else begin
         link.cmd_valid <= wr_cmd && rw_en && !stopped && (!is_pe || blk_ok) && !is_clr; // R2
         link.cmd_byte  <= wd;
         link.cmd_block <= cmd_blk;
      end
   end
   // Errors: set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         perr <= 1'b0;
         eerr <= 1'b0;
      end else begin
         perr <= (link.seq_done && link.seq_fail && !link.seq_op_erase) || (perr && !(is_clr && rw_en)); // R8 R18
         eerr <= (link.seq_done && link.seq_fail &&  link.seq_op_erase) || (eerr && !(is_clr && rw_en)); // R8 R18
      end
   end
   // Progress flags follow the sequencer, held through suspend
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         eprog <= 1'b0;
         pprog <= 1'b0;
      end else begin
         eprog <= link.seq_busy && link.seq_op_erase && !link.seq_done;               // R13
         pprog <= link.seq_busy && !link.seq_op_erase && !link.seq_done;              // R14
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Suspend control
   wire e_win = sus_en && eprog;
   wire p_win = sus_en && pprog;
   // Request bits read 0 outside their window, so no stale request survives an op
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sus_en <= 1'b0;
         esus   <= 1'b0;
         psus   <= 1'b0;
         lpr    <= 1'b0;
      end else begin
         if (wr_sus) begin
            sus_en <= wd[`FRC_B_SUS_EN] && (sus_en || ok_sus);                        // R10
            lpr    <= wd[`FRC_B_LPR];                                                 // R16
         end
         esus <= e_win && ((sel && irq_pending) ||                                    // R11
                 (wr_sus ? (wd[`FRC_B_ESUS] && !sel) || (sel && esus && wd[`FRC_B_ESUS]) : esus));
         psus <= p_win && ((sel && irq_pending) ||                                    // R12
                 (wr_sus ? (wd[`FRC_B_PSUS] && !sel) || (sel && psus && wd[`FRC_B_PSUS]) : psus));
      end
   end
   // Link levels and the access block, all registered
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         link.suspend_req   <= 1'b0;
         link.flash_reset   <= 1'b0;
         flash_access_block <= 1'b0;
      end else begin
         link.suspend_req   <= esus || psus;                                          // R10
         link.flash_reset   <= stopped;                                               // R6
         flash_access_block <= stopped || !rdok;                                      // R6 R15
      end
   end
endmodule : frc_ctrl

// ---- rtl/frc_defs.svh ----
/*
 Constants for the flash rewrite control flags: register indices, bit positions,
 reset values and command bytes. Assumes nothing; definitions only.
*/
`ifndef FRC_DEFS_SVH
`define FRC_DEFS_SVH
// Register byte addresses on the AHB-Lite window
`define FRC_ADDR_STATUS   4'h0
`define FRC_ADDR_MODE     4'h4
`define FRC_ADDR_SUSPEND  4'h8
`define FRC_ADDR_COMMAND  4'hc
// Status/control register bits
`define FRC_B_READY       0
`define FRC_B_RW_EN       1
`define FRC_B_LOCK_REL    2
`define FRC_B_STOP        3
`define FRC_B_PERR        6
`define FRC_B_EERR        7
// Mode register bits
`define FRC_B_SEL         1
`define FRC_B_LOCK0       5
`define FRC_B_LOCK1       6
// Suspend register bits
`define FRC_B_SUS_EN      0
`define FRC_B_ESUS        1
`define FRC_B_PSUS        2
`define FRC_B_EPROG       3
`define FRC_B_PPROG       4
`define FRC_B_RDOK        6
`define FRC_B_LPR         7
// Reset values
`define FRC_RST_STATUS    8'h01
`define FRC_RST_MODE      8'h60
`define FRC_RST_SUSPEND   8'h00
// Command bytes
`define FRC_CMD_CLEAR     8'h50
`define FRC_CMD_PROGRAM   8'h40
`define FRC_CMD_ERASE     8'h20
// Protected-write window in cycles after the arming write
`define FRC_ARM_WINDOW    4'h8
`endif

// ---- rtl/frc_link_if.sv ----
/*
 Link between the rewrite control flag block and the flash sequencer side.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface frc_link_if;
   logic       cmd_valid;    // One-cycle command strobe
   logic [7:0] cmd_byte;     // Command code
   logic [1:0] cmd_block;    // Target block
   logic       cmd_accept;   // Command accepted, one cycle
   logic       seq_busy;     // Operation running
   logic       seq_op_erase; // Running op is erase
   logic       seq_done;     // One-cycle end of op
   logic       seq_fail;     // With done: op failed
   logic       suspend_req;  // Level: hold the op
   logic       suspended;    // Op is held
   logic       flash_reset;  // Level: stop and reset flash
   modport ctrl (output cmd_valid, cmd_byte, cmd_block, suspend_req, flash_reset,
                 input cmd_accept, seq_busy, seq_op_erase, seq_done, seq_fail, suspended);
   modport seq  (input cmd_valid, cmd_byte, cmd_block, suspend_req, flash_reset,
                 output cmd_accept, seq_busy, seq_op_erase, seq_done, seq_fail, suspended);
endinterface : frc_link_if

// ---- rtl/frc_pkg.sv ----
/*
 Types shared by both ends of the flash rewrite control link.
 Assumes frc_defs.svh is on the include path.
*/
package frc_pkg;
   // Sequencer operation kinds
   typedef enum logic [1:0] {FRC_OP_NONE, FRC_OP_PROGRAM, FRC_OP_ERASE} frc_op_t;
   // Host bus phase
   typedef enum logic [1:0] {FRC_H_IDLE, FRC_H_ADDR, FRC_H_DATA} frc_hstate_t;
endpackage : frc_pkg

// ---- rtl/frc_seq.sv ----
/*
 Sequencer end: runs auto-program and auto-erase for a set number of cycles,
 honours suspend and the flash reset. Assumes the control end on the link.
*/
`timescale 1ns/100ps
`include "frc_defs.svh"
module frc_seq
   import frc_pkg::*;
#(
   parameter int OP_CYCLES = 64      // Length of one operation
)(
   input  wire logic sys_clk,        // Clock
   input  wire logic resetn,         // Sync reset
   input  wire logic inject_fail,    // Make the next op fail
   output logic      op_active,      // Operation in flight
   frc_link_if.seq   link            // Control side
);
   import frc_pkg::*;
   frc_op_t     op;                  // Running operation
   logic [15:0] cnt;                 // Remaining cycles
   logic        fail;                // Latched failure
   logic        erase_kind;          // Kind of latest op, kept past its end
   wire go = link.cmd_valid && op == FRC_OP_NONE &&
             (link.cmd_byte == `FRC_CMD_PROGRAM || link.cmd_byte == `FRC_CMD_ERASE);
   // Operation counter; suspend freezes it, reset aborts it
   always_ff @(posedge sys_clk) begin
      if (!resetn || link.flash_reset) begin
         op              <= FRC_OP_NONE;
         cnt             <= 16'h0;
         fail            <= 1'b0;
         erase_kind      <= 1'b0;
         link.cmd_accept <= 1'b0;
         link.seq_done   <= 1'b0;
      end else begin
         link.cmd_accept <= go;
         link.seq_done   <= 1'b0;
         case (op)
            FRC_OP_NONE: begin
               if (go) begin
                  op   <= (link.cmd_byte == `FRC_CMD_ERASE) ? FRC_OP_ERASE : FRC_OP_PROGRAM;
                  cnt  <= 16'(OP_CYCLES);
                  fail <= inject_fail;
                  erase_kind <= (link.cmd_byte == `FRC_CMD_ERASE);
               end
            end
            default: begin
               if (!link.suspend_req) begin
                  if (cnt == 16'h1) begin
                     op <= FRC_OP_NONE;
                     link.seq_done <= 1'b1;
                  end
                  cnt <= cnt - 16'h1;
               end
            end
         endcase
      end
   end
   assign link.seq_busy     = op != FRC_OP_NONE;
   // Kind stays valid in the done cycle, so a failure lands in the right flag
   assign link.seq_op_erase = erase_kind;
   assign link.seq_fail     = fail;
   assign link.suspended    = link.seq_busy && link.suspend_req;
   assign op_active         = link.seq_busy;
endmodule : frc_seq

// ---- testbench/frc_link_assertions.sv ----
/* Checker for the link between the control and sequencer ends.
   Assumes one clock and the link signals wired in as plain inputs. */
`timescale 1ns/100ps
module frc_link_assertions (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic cmd_accept,
   input wire logic seq_busy,
   input wire logic seq_op_erase,
   input wire logic seq_done,
   input wire logic suspend_req,
   input wire logic suspended,
   input wire logic flash_reset
);
   // One domain, so one default clock and reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   chk_accept_after_cmd: assert property (cmd_accept |-> $past(cmd_valid))
      else $error("accept without command");
   chk_accept_starts_op: assert property (cmd_accept |-> seq_busy)
      else $error("accepted op not busy");
   chk_done_one_cycle: assert property (seq_done |=> !seq_done)
      else $error("done longer than a cycle");
   chk_done_ends_op: assert property (seq_done |-> ##[0:1] !seq_busy)
      else $error("busy after done");
   chk_held_in_op: assert property (suspended |=> !seq_done)
      else $error("op ended while held");
   chk_op_min_length: assert property ($rose(seq_busy) |-> !seq_done [*8])
      else $error("op ended too early");
   chk_stop_aborts: assert property (flash_reset |-> ##[0:2] !seq_busy)
      else $error("op survives flash reset");
   chk_suspend_taken: assert property (suspend_req && seq_busy && !seq_done |-> ##[0:8] suspended)
      else $error("suspend not entered");
   chk_resume_taken: assert property ($fell(suspended) && seq_busy |-> ##[1:1000] !seq_busy)
      else $error("op not resumed");
   chk_kind_stable: assert property (seq_busy && $past(seq_busy) |-> $stable(seq_op_erase))
      else $error("op kind changed");
   // Main scenarios reached
   cover property (cmd_accept && seq_op_erase);
   cover property ($rose(suspended));
   cover property (seq_done);
   cover property (flash_reset);
endmodule : frc_link_assertions

// ---- testbench/test_flash_rewrite_control_flags.sv ----
/* Bench for the rewrite control pair: AHB-Lite master, random block trials,
   errors, suspend, stop. Assumes rtl/ on the include path. */
`timescale 1ns/100ps
`include "frc_defs.svh"
module test_flash_rewrite_control_flags;
   import frc_pkg::*;
   localparam int OPC = 16;              // Shortened op length
   logic        sys_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, r;
   logic [1:0]  htrans, eflags;          // eflags: expected error bits
   logic [2:0]  hsize;
   logic        irq_pending, inject_fail, flash_access_block, op_active;
   logic        sen;                     // Expected suspend enable bit
   int          err_count, checks_done;
   frc_link_if  link ();
   assign hready = hreadyout;            // Single slave drives ready
   frc_ctrl i_frc_ctrl (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq_pending(irq_pending),
      .flash_access_block(flash_access_block), .link(link.ctrl));
   frc_seq #(.OP_CYCLES(OPC)) i_frc_seq (.sys_clk(sys_clk), .resetn(resetn),
      .inject_fail(inject_fail), .op_active(op_active), .link(link.seq));
   frc_link_assertions i_frc_link_assertions (.sys_clk(sys_clk), .resetn(resetn),
      .cmd_valid(link.cmd_valid), .cmd_accept(link.cmd_accept), .seq_busy(link.seq_busy),
      .seq_op_erase(link.seq_op_erase), .seq_done(link.seq_done), .suspend_req(link.suspend_req),
      .suspended(link.suspended), .flash_reset(link.flash_reset));
   ////////////////////////////////////////////////////////////
   // Free-running 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One single transfer; no wait count assumed, hready decides
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      ahb(1'b0, a, 32'h0);
      check($sformatf("reg%h", a), rd, {24'h0, exp});
   endtask : rdchk
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : idle
   // Poll status until ready; the watchdog bounds a hang
   task automatic wait_ready;
      do ahb(1'b0, 8'h00, 32'h0); while (rd[0] !== 1'b1);
   endtask : wait_ready
   // Protection table: release gates all, locks gate blocks 0 and 1
   function automatic logic exp_ok(logic rel, logic l0, logic l1, logic [1:0] blk);
      if (!rel) return 1'b0;
      if (blk == 2'd0) return !l0;
      if (blk == 2'd1) return !l1;
      return 1'b1;
   endfunction : exp_ok
   task automatic op(input logic rel, input logic l0, input logic l1, input logic [1:0] blk, input logic ers);
      logic ok;
      ok = exp_ok(rel, l0, l1, blk);
      wr(8'h04, 32'h60);
      wr(8'h04, {25'h0, l1, l0, 5'h0});
      wr(8'h00, 32'h2);
      if (rel) wr(8'h00, 32'h6);
      wr(8'h0c, {22'h0, blk, ers ? 8'h20 : 8'h40});
      idle(3);
      rdchk(8'h00, {eflags, 3'h0, rel, 1'b1, !ok});
      check("access", {31'h0, flash_access_block}, {31'h0, ok});
      check("busy", {31'h0, op_active}, {31'h0, ok});
      rdchk(8'h08, {7'h0, sen} | (ok ? (ers ? 8'h08 : 8'h10) : 8'h40));
      if (ok) wait_ready;
   endtask : op
   // Suspend by software write or by interrupt, then resume
   task automatic susp(input logic held, input logic prog);
      wr(8'h0c, prog ? 32'h240 : 32'h220);
      idle(3);
      if (held) irq_pending <= 1'b1;
      else wr(8'h08, prog ? 32'h5 : 32'h3);
      idle(4);
      irq_pending <= 1'b0;
      rdchk(8'h08, prog ? 8'h55 : 8'h4b);
      rdchk(8'h00, 8'h06);
      wr(8'h08, 32'h1);
      wait_ready;
      rdchk(8'h08, 8'h41);
   endtask : susp
   // Watchdog, far beyond the expected run
   initial begin
      repeat (30000) @(posedge sys_clk);
      err_count++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata, irq_pending, inject_fail} = '0;
      hsize = 3'b010;
      {err_count, checks_done, eflags, sen} = '0;
      void'($urandom(21));
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      check("resp", {31'h0, hresp}, 32'h0);
      rdchk(8'h00, 8'h01);
      rdchk(8'h04, 8'h60);
      rdchk(8'h08, 8'h40);
      rdchk(8'h1c, 8'h00);
      // Unarmed enable, then a command that must be ignored
      wr(8'h00, 32'h2);
      wr(8'h0c, 32'h240);
      idle(3);
      rdchk(8'h00, 8'h01);
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h2);
      op(1'b1, 1'b0, 1'b0, 2'd0, 1'b0);
      op(1'b1, 1'b0, 1'b1, 2'd1, 1'b1);
      op(1'b0, 1'b0, 1'b0, 2'd2, 1'b1);
      for (int i = 0; i < 14; i++) begin
         r = $urandom;
         op(r[0], r[1], r[2], r[4:3], r[5]);
      end
      // Failing ops, read-only flags, wrong and right clear codes
      inject_fail <= 1'b1;
      op(1'b1, 1'b0, 1'b0, 2'd2, 1'b0);
      eflags = 2'b01;
      op(1'b1, 1'b0, 1'b0, 2'd3, 1'b1);
      eflags = 2'b11;
      inject_fail <= 1'b0;
      wr(8'h00, 32'h6);
      wr(8'h0c, 32'h70);
      idle(2);
      rdchk(8'h00, 8'hc7);
      wr(8'h0c, 32'h50);
      idle(2);
      rdchk(8'h00, 8'h07);
      eflags = 2'b00;
      // Suspend with enable off is refused
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'h320);
      idle(3);
      wr(8'h08, 32'h2);
      idle(2);
      rdchk(8'h08, 8'h08);
      wait_ready;
      wr(8'h08, 32'h0);
      wr(8'h08, 32'h1);
      sen = 1'b1;
      susp(1'b0, 1'b0);
      susp(1'b0, 1'b1);
      op(1'b1, 1'b0, 1'b0, 2'd2, 1'b0);
      wr(8'h04, 32'h0);
      wr(8'h04, 32'h2);
      rdchk(8'h04, 8'h02);
      susp(1'b1, 1'b0);
      susp(1'b1, 1'b1);
      // Disable clears release and select; locks then frozen
      wr(8'h00, 32'h0);
      rdchk(8'h00, 8'h01);
      rdchk(8'h04, 8'h00);
      wr(8'h04, 32'h60);
      rdchk(8'h04, 8'h00);
      // Stop stored but idle while disabled, active once enabled
      wr(8'h00, 32'h8);
      rdchk(8'h00, 8'h09);
      check("freset", {31'h0, link.flash_reset}, 32'h0);
      wr(8'h00, 32'ha);
      idle(2);
      check("freset", {31'h0, link.flash_reset}, 32'h1);
      check("access", {31'h0, flash_access_block}, 32'h1);
      end_sim();
   end
endmodule : test_flash_rewrite_control_flags
